// ---- hdl/wcm_pkg.sv ----
// constants and types for the windowed watchdog with clock monitor
package wcm_pkg;
    localparam int          CLK_HZ       = 100_000_000;
    localparam int          CM_MIN_HZ    = 5_000;
    localparam int          CM_LIMIT     = CLK_HZ / CM_MIN_HZ;
    localparam int          HOLD_CYCLES  = 24;
    localparam int          KEY_MSB      = 5;
    localparam int          KEY_LSB      = 1;
    localparam int          WIN_MSB      = 7;
    localparam int          WIN_LSB      = 6;
    localparam int          CM_BIT       = 0;
    localparam logic [4:0]  KEY_VALUE    = 5'h0C;
    localparam logic [4:0]  KEY_READ     = 5'h00;
    localparam logic [1:0]  WIN_RESET    = 2'h3;
    localparam logic        CM_RESET     = 1'b1;
    localparam logic [16:0] LOWER_LIMIT  = 17'h00800;
    localparam logic [16:0] UPPER_BASE   = 17'h02000;
    localparam int          CNT_W        = 17;
    localparam int          IDLE_W       = 16;
    localparam int          TAP_LSB      = 12;
    localparam logic [2:0]  TAP_MAX      = 3'h4;

    typedef enum logic [3:0] {
        WCM_ARMED = 4'h1,
        WCM_DRIVE = 4'h2,
        WCM_HOLD  = 4'h4,
        WCM_WAIT  = 4'h8
    } wcm_state_e;
endpackage

// ---- hdl/wcm_idle_if.sv ----
// signals between the watchdog control and the idle timer
`timescale 1ns/10ps
`default_nettype none
interface wcm_idle_if;
    logic                      idleEdge;
    logic [wcm_pkg::IDLE_W-1:0] count;
    logic [2:0]                tapSel;
    logic                      pendClear;
    logic                      pending;

    modport timer (output idleEdge, output count, output pending,
                   input tapSel, input pendClear);
    modport ctrl  (input idleEdge, input count, input pending,
                   output tapSel, output pendClear);
endinterface
`default_nettype wire

// ---- hdl/wcm_idle_timer.sv ----
// idle timer counter with tick pending flag
`timescale 1ns/10ps
`default_nettype none
module wcm_idle_timer
    import wcm_pkg::*;
(
    input  wire logic clk,        // system clock
    input  wire logic porReset,   // power-on reset only
    input  wire logic idleClkPin, // idle timer clock pin
    wcm_idle_if.timer tmr         // link to watchdog control
);
    logic              syncA;
    logic              syncB;
    logic              syncPrev;
    logic [IDLE_W-1:0] count;
    logic              pending;
    logic              tapPrev;
    wire  logic [2:0]  tapIdx  = (tmr.tapSel > TAP_MAX) ? TAP_MAX : tmr.tapSel;
    wire  logic        tapBit  = count[TAP_LSB + int'(tapIdx)];
    wire  logic        edgeNow = syncB & ~syncPrev;
    wire  logic        tapFlip = tapBit ^ tapPrev;

    // external reset does not reach the counter, see R11
    always_ff @(posedge clk or posedge porReset) begin
        if (porReset) begin
            syncA    <= 1'b0;
            syncB    <= 1'b0;
            syncPrev <= 1'b0;
            count    <= '0;
            tapPrev  <= 1'b0;
        end else begin
            syncA    <= idleClkPin;
            syncB    <= syncA;
            syncPrev <= syncB;
            count    <= edgeNow ? count + 1'b1 : count;
            tapPrev  <= tapBit;
        end
    end

    // set wins over software clear, see R12 and R13
    always_ff @(posedge clk or posedge porReset) begin
        if (porReset) begin
            pending <= 1'b0;
        end else if (tapFlip) begin
            pending <= 1'b1;
        end else if (tmr.pendClear) begin
            pending <= 1'b0;
        end
    end

    assign tmr.idleEdge = edgeNow;
    assign tmr.count    = count;
    assign tmr.pending  = pending;
endmodule
`default_nettype wire

// ---- hdl/wcm_watchdog.sv ----
// windowed watchdog and clock monitor, top level
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// R1 - while reset is held neither detector runs nor raises a fault
// R2 - after reset the longest window is selected and the monitor enabled
// R3 - window and monitor choice are latched only by the first service
// R4 - first service is checked against the key only; mismatch faults
// R5 - later services compare key, window and monitor bit; mismatch faults
// R6 - reads of the service register show zeros in the key field
// R7 - timeout detection is suspended during halt and idle
// R8 - clock monitor keeps running in halt and idle
// R9 - clock monitor fault drives the fault output low while it lasts
// R10 - after halt the window restarts at the stored selection
// R11 - external reset leaves the idle timer counter running
// R12 - pending flag sets when the selected idle counter tap toggles
// R13 - software clears the pending flag; hardware never clears it
// R14 - leaving idle performs a hardware service
// R15 - first service accepted anywhere in the reset window, no lower check
// R16 - return from boot code services and re-enables lower checking
// R17 - lower limit is 2048 counts; an earlier service faults
// R18 - key field is bits five to one and must match the fixed pattern
// R19 - watchdog fault holds output low, releases, restarts when pin high
// R20 - service writes while the fault output is driven are ignored; code ignores them only when not armed, not in a monitor fault
// R21 - window select bits give 8k, 16k, 32k or 64k upper limit
// R22 - bit zero enables the clock monitor when one
module wcm_watchdog
    import wcm_pkg::*;
#(
    parameter int CM_LIMIT_CYCLES = CM_LIMIT,
    parameter int HOLD_COUNT      = HOLD_CYCLES
)(
    input  wire logic       clk,             // system clock, 100 MHz
    input  wire logic       reset,           // external reset, async high
    input  wire logic       porReset,        // power-on reset, async high
    input  wire logic       idleClkPin,      // idle timer clock pin
    input  wire logic       cycleStrobePin,  // instruction cycle clock pin
    input  wire logic       highSpeedMode,   // 1: count cycles, 0: idle clocks
    input  wire logic       haltMode,        // device in halt
    input  wire logic       idleMode,        // device in idle
    input  wire logic       bootEnter,       // pulse, jump into boot code
    input  wire logic       bootReturn,      // pulse, return to user code
    input  wire logic       svcWrite,        // pulse, service register write
    input  wire logic [7:0] svcWdata,        // service write data
    output logic      [7:0] svcRdata,        // service register read value
    input  wire logic [2:0] idleTickSel,     // idle tick interval select
    input  wire logic       idleTickClear,   // pulse, clear pending flag
    output logic            idleTickPending, // idle tick pending flag
    output logic            faultOut,        // fault pin output level
    output logic            faultOutOe,      // fault pin driven low when high
    input  wire logic       faultPin,        // fault pin level
    output logic            wdFault,         // watchdog fault in progress
    output logic            cmFault,         // clock monitor fault active
    output logic            firstDone        // first service taken
);
    localparam int CMW = $clog2(CM_LIMIT_CYCLES + 1);
    localparam int HW  = $clog2(HOLD_COUNT + 1);
    localparam logic [CMW-1:0] CM_LIM = CMW'(CM_LIMIT_CYCLES);
    localparam logic [HW-1:0]  HOLD_L = HW'(HOLD_COUNT);

    wcm_idle_if idleBus ();

    wcm_idle_timer u_idle (
        .clk        (clk),
        .porReset   (porReset),
        .idleClkPin (idleClkPin),
        .tmr        (idleBus)
    );

    assign idleBus.tapSel    = idleTickSel;
    assign idleBus.pendClear = idleTickClear;
    assign idleTickPending   = idleBus.pending;

    // pin synchronisers
    logic pinA;
    logic pinB;
    logic stbA;
    logic stbB;
    logic stbPrev;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pinA    <= 1'b1;
            pinB    <= 1'b1;
            stbA    <= 1'b0;
            stbB    <= 1'b0;
            stbPrev <= 1'b0;
        end else begin
            pinA    <= faultPin;
            pinB    <= pinA;
            stbA    <= cycleStrobePin;
            stbB    <= stbA;
            stbPrev <= stbB;
        end
    end

    // stored configuration
    logic [1:0] winSel;
    logic       cmEn;
    logic       lowerEn;
    logic       suspPrev;

    // window state
    wcm_state_e           state;
    wcm_state_e           next_state;
    logic [CNT_W-1:0]     wdCount;
    logic [HW-1:0]        holdCnt;
    logic [CMW-1:0]       cmCount;

    // field decode
    wire logic [4:0] keyField  = svcWdata[KEY_MSB:KEY_LSB];
    wire logic [1:0] winField  = svcWdata[WIN_MSB:WIN_LSB];
    wire logic       cmField   = svcWdata[CM_BIT];
    wire logic       keyOk     = (keyField == KEY_VALUE);              // see R18
    wire logic       winOk     = (winField == winSel);
    wire logic       cmOk      = (cmField == cmEn);
    wire logic       fieldsOk  = firstDone ? (keyOk & winOk & cmOk)   // see R5
                                           : keyOk;                    // see R4
    wire logic       armed     = (state == WCM_ARMED);
    wire logic       svcTaken  = svcWrite & armed;                     // see R20
    wire logic       tooEarly  = lowerEn & (wdCount < LOWER_LIMIT);    // see R17
    wire logic       svcGood   = svcTaken & fieldsOk & ~tooEarly;
    wire logic       svcBad    = svcTaken & ~(fieldsOk & ~tooEarly);

    // timebase and suspension
    wire logic       suspended = haltMode | idleMode;
    wire logic       suspEnd   = suspPrev & ~suspended;               // see R10
    wire logic       tick      = highSpeedMode ? 1'b1 : idleBus.idleEdge;
    wire logic [CNT_W-1:0] upperLimit = UPPER_BASE << winSel;          // see R21
    wire logic       timeout   = armed & ~suspended                   // see R7
                               & (wdCount >= upperLimit - 1'b1) & tick;
    wire logic       hwService = bootEnter | bootReturn | suspEnd;     // see R14
    wire logic       restart   = svcGood | hwService;

    // clock monitor decode
    wire logic       stbEdge   = stbB & ~stbPrev;
    wire logic       cmSlow    = (cmCount >= CM_LIM);

    // configuration latched on first good service only
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            winSel    <= WIN_RESET;                                   // see R2
            cmEn      <= CM_RESET;
            firstDone <= 1'b0;
        end else if (svcGood & ~firstDone) begin
            winSel    <= winField;                                    // see R3
            cmEn      <= cmField;                                     // see R22
            firstDone <= 1'b1;
        end
    end

    // lower limit checking enable
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            lowerEn <= 1'b0;                                          // see R15
        end else if (bootEnter) begin
            lowerEn <= 1'b0;
        end else if (bootReturn | svcGood) begin
            lowerEn <= 1'b1;                                          // see R16
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            suspPrev <= 1'b0;
        end else begin
            suspPrev <= suspended;
        end
    end

    // window counter
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wdCount <= '0;
        end else if (!armed || restart) begin
            wdCount <= '0;
        end else if (!suspended && tick) begin
            wdCount <= wdCount + 1'b1;
        end
    end

    // fault sequencing
    always_comb begin
        next_state = state;
        unique case (state)
            WCM_ARMED: begin
                if (svcBad || timeout) begin
                    next_state = WCM_DRIVE;
                end
            end
            WCM_DRIVE: begin
                if (!pinB) begin
                    next_state = WCM_HOLD;
                end
            end
            WCM_HOLD: begin
                if (holdCnt == HOLD_L) begin
                    next_state = WCM_WAIT;                            // see R19
                end
            end
            WCM_WAIT: begin
                if (pinB) begin
                    next_state = WCM_ARMED;
                end
            end
        endcase
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state <= WCM_ARMED;                                       // see R1
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            holdCnt <= '0;
        end else if (state == WCM_HOLD) begin
            holdCnt <= holdCnt + 1'b1;
        end else begin
            holdCnt <= '0;
        end
    end

    // clock monitor, runs through halt and idle
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cmCount <= '0;
        end else if (stbEdge) begin
            cmCount <= '0;
        end else if (!cmSlow) begin
            cmCount <= cmCount + 1'b1;                                // see R8
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cmFault <= 1'b0;
        end else begin
            cmFault <= cmEn & cmSlow & ~stbEdge;
        end
    end

    // outputs
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            svcRdata <= {WIN_RESET, KEY_READ, CM_RESET};
        end else begin
            svcRdata <= {winSel, KEY_READ, cmEn};                     // see R6
        end
    end

    assign wdFault    = (state == WCM_DRIVE) | (state == WCM_HOLD);
    assign faultOutOe = wdFault | cmFault;                            // see R9
    assign faultOut   = 1'b0;
endmodule
`default_nettype wire

// ---- test/wcm_pin_model.sv ----
// fault pin with its on-chip pull-up
`timescale 1ns/10ps
`default_nettype none
module wcm_pin_model (
    input  wire logic faultOutOe, // device sinks the pin when high
    output logic      faultPin    // resolved pin level
);
    // nobody else sinks it, so the pull-up wins when released
    assign faultPin = faultOutOe ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

// ---- test/wcm_watchdog_checker.sv ----
// port-level assertions for the watchdog
`timescale 1ns/10ps
`default_nettype none
module wcm_watchdog_checker
    import wcm_pkg::*;
#(
    parameter int CM_LIMIT_CYCLES = CM_LIMIT,
    parameter int HOLD_COUNT      = HOLD_CYCLES
)(
    input wire logic       clk,            // clock
    input wire logic       reset,          // reset
    input wire logic       cycleStrobePin, // cycle clock
    input wire logic       svcWrite,       // write strobe
    input wire logic [7:0] svcWdata,       // write data
    input wire logic [7:0] svcRdata,       // readback
    input wire logic       faultOut,       // pin output level
    input wire logic       faultOutOe,     // pin drive
    input wire logic       faultPin,       // pin level
    input wire logic       wdFault,        // watchdog fault
    input wire logic       cmFault,        // monitor fault
    input wire logic       firstDone       // first service taken
);
    default clocking @(posedge clk); endclocking
    int   stillCnt;
    logic keyOk;
    assign keyOk = svcWdata[KEY_MSB:KEY_LSB] == KEY_VALUE;
    // cycles the cycle clock has sat low
    always_ff @(posedge clk) begin
        stillCnt <= cycleStrobePin ? 0 : stillCnt + 1;
    end
    chk_reset_quiet: assert property (reset |-> !wdFault && !cmFault && !faultOutOe)
        else $error("fault active in reset");
    chk_reset_dflt: assert property ($fell(reset) |-> svcRdata == 8'hC1 && !firstDone)
        else $error("bad reset defaults");
    chk_first_badkey: assert property (disable iff (reset) faultPin[*4] ##0 (svcWrite
        && !faultOutOe && !firstDone && !keyOk) |=> faultOutOe) else $error("bad key taken");
    chk_first_latch: assert property (disable iff (reset) faultPin[*4] ##0 (svcWrite
        && !faultOutOe && !firstDone && keyOk) |=> firstDone ##1 svcRdata ==
        {$past(svcWdata[7:6], 2), KEY_READ, $past(svcWdata[0], 2)}) else $error("latch wrong");
    chk_latch_kept: assert property (disable iff (reset) $past(firstDone, 2) |->
        $stable(svcRdata)) else $error("choice changed");
    chk_key_hidden: assert property (svcRdata[KEY_MSB:KEY_LSB] == KEY_READ)
        else $error("key visible");
    chk_later_bad: assert property (disable iff (reset) faultPin[*4] ##0 (svcWrite
        && !faultOutOe && $past(firstDone, 2) && firstDone && svcWdata !=
        {svcRdata[7:6], KEY_VALUE, svcRdata[0]}) |=> faultOutOe) else $error("mismatch taken");
    chk_cm_drive: assert property (disable iff (reset) cmFault |-> faultOutOe
        && faultOut == 1'b0) else $error("monitor fault not driven");
    chk_cm_detect: assert property (disable iff (reset) svcRdata[CM_BIT]
        && stillCnt == CM_LIMIT_CYCLES + 8 |-> cmFault) else $error("stop not seen");
    chk_wd_hold: assert property (disable iff (reset) $fell(faultPin) && wdFault
        |-> ##16 faultOutOe ##[1:20] !faultOutOe) else $error("hold length wrong");
endmodule
bind wcm_watchdog wcm_watchdog_checker #(.CM_LIMIT_CYCLES(CM_LIMIT_CYCLES),
    .HOLD_COUNT(HOLD_COUNT)) u_chk (.clk(clk), .reset(reset),
    .cycleStrobePin(cycleStrobePin), .svcWrite(svcWrite), .svcWdata(svcWdata),
    .svcRdata(svcRdata), .faultOut(faultOut), .faultOutOe(faultOutOe),
    .faultPin(faultPin), .wdFault(wdFault), .cmFault(cmFault), .firstDone(firstDone));
`default_nettype wire

// ---- test/windowed_watchdog_clock_monitor_tb_top.sv ----
// self-checking bench for the windowed watchdog
`timescale 1ns/10ps
`default_nettype none
module windowed_watchdog_clock_monitor_tb_top;
    import wcm_pkg::*;
    localparam int CML = 50;
    logic       clk, reset, porReset, highSpeedMode;
    logic       idleClkPin = 1'b0, cycleStrobePin = 1'b0;
    logic       haltMode, idleMode, bootEnter, bootReturn, svcWrite, idleTickClear;
    logic [7:0] svcWdata, svcRdata;
    logic [2:0] idleTickSel;
    logic       idleTickPending, faultOut, faultOutOe, faultPin, wdFault, cmFault;
    logic       firstDone, strobeOn, idleOn;
    int         bad_count, total_checks, cycles;

    wcm_watchdog #(.CM_LIMIT_CYCLES(CML), .HOLD_COUNT(24)) uut (.clk(clk), .reset(reset),
        .porReset(porReset), .idleClkPin(idleClkPin), .cycleStrobePin(cycleStrobePin),
        .highSpeedMode(highSpeedMode), .haltMode(haltMode), .idleMode(idleMode),
        .bootEnter(bootEnter), .bootReturn(bootReturn), .svcWrite(svcWrite),
        .svcWdata(svcWdata), .svcRdata(svcRdata), .idleTickSel(idleTickSel),
        .idleTickClear(idleTickClear), .idleTickPending(idleTickPending),
        .faultOut(faultOut), .faultOutOe(faultOutOe), .faultPin(faultPin),
        .wdFault(wdFault), .cmFault(cmFault), .firstDone(firstDone));
    wcm_pin_model pin (.faultOutOe(faultOutOe), .faultPin(faultPin));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        cycleStrobePin <= strobeOn ? ~cycleStrobePin : 1'b0;
        if (idleOn) idleClkPin <= ~idleClkPin;
        if (cycles == 80000) begin
            bad_count++;
            summarize();
        end
    end

    task automatic summarize;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic write(input logic [7:0] d);
        @(posedge clk);
        svcWrite <= 1'b1;
        svcWdata <= d;
        @(posedge clk);
        svcWrite <= 1'b0;
    endtask
    task automatic waitOe(input logic lvl, input int n);
        int i;
        @(negedge clk);
        for (i = 0; i < n && faultOutOe !== lvl; i++) @(negedge clk);
        check(faultOutOe, lvl);
    endtask
    task automatic doReset;
        @(posedge clk);
        reset <= 1'b1;
        tick(16);
        reset <= 1'b0;
    endtask

    task automatic testBadKey;
        @(negedge clk);
        check(svcRdata, 8'hC1);
        check({wdFault, cmFault, faultOutOe, firstDone}, 8'h00);
        write(8'hC3);
        waitOe(1'b1, 2);
        write(8'hD9);
        tick(14);
        check(faultOutOe, 1'b1);
        waitOe(1'b0, 30);
        check(firstDone, 1'b0);
    endtask
    task automatic testEarly;
        doReset();
        write(8'h18);
        @(negedge clk);
        check(firstDone, 1'b1);
        @(negedge clk);
        check(svcRdata, 8'h00);
        write(8'h18);
        waitOe(1'b1, 2);
        waitOe(1'b0, 40);
    endtask
    task automatic testLater;
        logic [7:0] bad [3] = '{8'h99, 8'h58, 8'h5B};
        doReset();
        write(8'h59);
        tick(2100);
        write(8'h59);
        @(negedge clk);
        check(faultOutOe, 1'b0);
        check(svcRdata, 8'h41);
        foreach (bad[i]) begin
            tick(2100);
            write(bad[i]);
            waitOe(1'b1, 2);
            waitOe(1'b0, 40);
        end
        check(svcRdata, 8'h41);
    endtask
    task automatic testTimeout;
        doReset();
        write(8'h18);
        tick(8100);
        @(negedge clk);
        check(faultOutOe, 1'b0);
        waitOe(1'b1, 200);
        waitOe(1'b0, 40);
    endtask
    task automatic testHalt;
        doReset();
        write(8'h18);
        @(posedge clk);
        haltMode <= 1'b1;
        strobeOn <= 1'b0;
        tick(9000);
        haltMode <= 1'b0;
        strobeOn <= 1'b1;
        @(negedge clk);
        check({wdFault, cmFault}, 8'h00);
        write(8'h18);
        waitOe(1'b1, 2);
        waitOe(1'b0, 40);
        tick(2100);
        idleMode <= 1'b1;
        tick(50);
        idleMode <= 1'b0;
        write(8'h18);
        waitOe(1'b1, 2);
        waitOe(1'b0, 40);
    endtask
    task automatic testMonitor;
        doReset();
        haltMode <= 1'b1;
        strobeOn <= 1'b0;
        tick(CML + 20);
        haltMode <= 1'b0;
        strobeOn <= 1'b1;
        check({cmFault, faultOutOe}, 8'h03);
        tick(10);
        @(negedge clk);
        check({cmFault, faultOutOe}, 8'h00);
    endtask
    task automatic testBoot;
        doReset();
        write(8'h18);
        tick(2100);
        bootEnter <= 1'b1;
        @(posedge clk);
        bootEnter <= 1'b0;
        write(8'h18);
        @(negedge clk);
        check(faultOutOe, 1'b0);
        @(posedge clk);
        bootReturn <= 1'b1;
        @(posedge clk);
        bootReturn <= 1'b0;
        tick(2100);
        write(8'h18);
        @(negedge clk);
        check(faultOutOe, 1'b0);
    endtask
    task automatic testIdleTick;
        int i;
        @(posedge clk);
        porReset <= 1'b1;
        idleOn <= 1'b1;
        @(posedge clk);
        porReset <= 1'b0;
        tick(4000);
        doReset();
        tick(4000);
        @(negedge clk);
        check(idleTickPending, 1'b0);
        for (i = 0; i < 300 && idleTickPending !== 1'b1; i++) @(negedge clk);
        check(idleTickPending, 1'b1);
        @(posedge clk);
        idleTickClear <= 1'b1;
        @(posedge clk);
        idleTickClear <= 1'b0;
        @(negedge clk);
        check(idleTickPending, 1'b0);
    endtask
    // window counted in idle clocks: 2100 cycles is only about 1050 of them
    task automatic testSlowBase;
        doReset();
        highSpeedMode <= 1'b0;
        write(8'h18);
        tick(2100);
        write(8'h18);
        waitOe(1'b1, 2);
        waitOe(1'b0, 40);
        tick(4200);
        write(8'h18);
        @(negedge clk);
        check(faultOutOe, 1'b0);
    endtask

    initial begin
        // nba so the async resets see a rising edge at time zero
        reset    <= 1'b1;
        porReset <= 1'b1;
        {strobeOn, highSpeedMode} = 2'h3;
        {haltMode, idleMode, bootEnter, bootReturn} = 4'h0;
        {svcWrite, idleTickClear, idleOn} = 3'h0;
        svcWdata = 8'h00;
        idleTickSel = 3'h0;
        tick(16);
        reset <= 1'b0;
        porReset <= 1'b0;
        testBadKey();
        testEarly();
        testLater();
        testTimeout();
        testHalt();
        testMonitor();
        testBoot();
        testIdleTick();
        testSlowBase();
        summarize();
    end
endmodule
`default_nettype wire
